// >>> hdl/dim_defs.svh
// Operation
// - With dimming function active, the contact drives on, off, brighter, darker and stop.
// - A contact change is taken only after staying stable for the debounce time.
// - Debounce times of one second or more act as a turn-on delay.
// - A press held at least the long threshold is a long push, except the second press of a double click.
// - Double-click detection only when enabled; otherwise every short press is a single click.
// - Double-click only if the second press begins within the window after the first press is released.
// - One-button: short push toggles on/off, long push alternates brighter and darker.
// - Releasing a long push sends stop unless a restoration or block-set on/off command falls in the same cycle.
// - Rocker halves: up sends on or toggle and dims up; down sends off or toggle, dims down.
// - Increment 100 percent: continuous dimming until release.
// - Stepped increment: long push changes the value by the selected step.
// - On restoration: nothing, switch on or switch off.
// - The restoration action may be delayed by 5, 10 or 15 seconds.
// - Block function works only when enabled; otherwise block values have no effect.
// - Block polarity: default 1 blocks and 0 enables; inverted 0 blocks and 1 enables.
// - Ignore-block option leaves the channel running as if never blocked.
// - Setting the block sends nothing, on or off as configured.
// - Cancelling the block sends nothing, on or off as configured.
`ifndef DIM_DEFS_SVH
`define DIM_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_CFG 8'h00
`define REG_BLOCK 8'h04
`define REG_STATUS 8'h08

// ****************************************
// Configuration fields
// ****************************************
`define F_DEB 0
`define F_LONG 3
`define F_DC_EN 6
`define F_DC_WIN 7
`define F_MODE 10
`define F_INC 13
`define F_REST_ACT 16
`define F_REST_DLY 18
`define F_BLK_EN 20
`define F_BLK_POL 21
`define F_BLK_SET 22
`define F_BLK_CLR 24
`define F_DIM_FN 26
`define CFG_W 27
`define CFG_RESET 27'h4000001

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000000
`define DEB_MS_0 30
`define DEB_MS_1 50
`define DEB_MS_2 80
`define DEB_MS_3 100
`define DEB_MS_4 200
`define DEB_MS_5 1000
`define DEB_MS_6 5000
`define DEB_MS_7 10000
`define SEL_BASE_MS 300
`define SEL_STEP_MS 100
`define RESTORE_STEP_MS 5000

`endif

// >>> hdl/dim_pkg.sv
package dim_pkg;

  typedef enum logic [2:0] {
    cmd_none, cmd_on, cmd_off, cmd_up, cmd_down, cmd_stop, cmd_double
  } dim_cmd_e;

  typedef enum logic [2:0] {
    mode_one, mode_up_on, mode_up_toggle, mode_down_off, mode_down_toggle
  } dim_mode_e;

  typedef enum logic [2:0] {
    st_idle, st_press, st_long, st_wait_dc, st_dc_press
  } press_state_e;

  typedef logic [13:0] ms_t;

endpackage

// >>> hdl/input_dimming_channel.sv
`timescale 1ns/1ps
`include "dim_defs.svh"

module input_dimming_channel #(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic contact_in,
  output logic [31:0] rd_data_out,
  output logic cmd_valid_out,
  output dim_pkg::dim_cmd_e cmd_out,
  output logic [2:0] step_out,
  output logic blocked_out,
  output logic level_out
);
  import dim_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  logic [`CFG_W-1:0] cfg_reg;
  logic blk_obj_reg;
  logic [31:0] rd_data_next;
  logic [31:0] status_word;
  wire sel_cfg = addr_in == `REG_CFG;
  wire sel_blk = addr_in == `REG_BLOCK;
  wire sel_sts = addr_in == `REG_STATUS;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_reg <= `CFG_RESET;
      blk_obj_reg <= 1'b0;
    end else if (wr_en_in) begin
      if (sel_cfg) begin
        cfg_reg <= wr_data_in[`CFG_W-1:0];
      end
      if (sel_blk) begin
        blk_obj_reg <= wr_data_in[0];
      end
    end
  end

  wire [2:0] deb_sel = cfg_reg[`F_DEB +: 3];
  wire [2:0] long_sel = cfg_reg[`F_LONG +: 3];
  wire dc_en = cfg_reg[`F_DC_EN];
  wire [2:0] win_sel = cfg_reg[`F_DC_WIN +: 3];
  wire [2:0] mode_bits = cfg_reg[`F_MODE +: 3];
  wire [2:0] inc_sel = cfg_reg[`F_INC +: 3];
  wire [1:0] rest_act = cfg_reg[`F_REST_ACT +: 2];
  wire [1:0] rest_dly = cfg_reg[`F_REST_DLY +: 2];
  wire blk_en = cfg_reg[`F_BLK_EN];
  wire blk_pol = cfg_reg[`F_BLK_POL];
  wire [1:0] blk_set = cfg_reg[`F_BLK_SET +: 2];
  wire [1:0] blk_clr = cfg_reg[`F_BLK_CLR +: 2];
  wire dim_fn = cfg_reg[`F_DIM_FN];
  wire dim_mode_e mode = dim_mode_e'(mode_bits);

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [17:0] tick_cnt_reg;
  wire tick = tick_cnt_reg == 18'(TICK_CYCLES - 1);
  wire [17:0] tick_cnt_next = tick ? 18'h0 : tick_cnt_reg + 18'h1;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_cnt_reg <= 18'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // ****************************************
  // Time selection
  // ****************************************
  function automatic ms_t deb_lut(input logic [2:0] s);
    unique case (s)
      3'h0: deb_lut = 14'(`DEB_MS_0);
      3'h1: deb_lut = 14'(`DEB_MS_1);
      3'h2: deb_lut = 14'(`DEB_MS_2);
      3'h3: deb_lut = 14'(`DEB_MS_3);
      3'h4: deb_lut = 14'(`DEB_MS_4);
      3'h5: deb_lut = 14'(`DEB_MS_5);
      3'h6: deb_lut = 14'(`DEB_MS_6);
      3'h7: deb_lut = 14'(`DEB_MS_7);
    endcase
  endfunction

  function automatic ms_t sel_ms(input logic [2:0] s);
    sel_ms = 14'(`SEL_BASE_MS + `SEL_STEP_MS * int'(s));
  endfunction

  wire ms_t deb_ms = deb_lut(deb_sel);
  wire ms_t long_ms = sel_ms(long_sel);
  wire ms_t win_ms = sel_ms(win_sel);
  wire ms_t rest_ms = 14'(`RESTORE_STEP_MS * int'(rest_dly));

  // ****************************************
  // Debounce
  // ****************************************
  logic cand_reg;
  logic level_reg;
  ms_t deb_t_reg;
  wire deb_done = deb_t_reg >= deb_ms;
  wire moved = contact_in != cand_reg;
  wire ms_t deb_t_next = moved ? 14'h0 :
    (tick && !deb_done) ? deb_t_reg + 14'h1 : deb_t_reg;
  wire level_next = (deb_done && !moved) ? cand_reg : level_reg;
  wire press_ev = level_next && !level_reg;
  wire release_ev = !level_next && level_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cand_reg <= 1'b0;
      level_reg <= 1'b0;
      deb_t_reg <= 14'h0;
    end else begin
      cand_reg <= contact_in;
      deb_t_reg <= deb_t_next;
      level_reg <= level_next;
    end
  end

  // ****************************************
  // Block object
  // ****************************************
  logic blocked_reg;
  wire blk_ignore = blk_set == 2'h0;
  wire blk_value = blk_obj_reg ^ blk_pol;
  wire blocked_next = blk_en && !blk_ignore && blk_value;
  wire blk_set_ev = blocked_next && !blocked_reg;
  wire blk_clr_ev = !blocked_next && blocked_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      blocked_reg <= 1'b0;
    end else begin
      blocked_reg <= blocked_next;
    end
  end

  // ****************************************
  // Press classification
  // ****************************************
  press_state_e state_reg;
  press_state_e state_next;
  ms_t p_t_reg;
  logic ev_short;
  logic ev_long;
  logic ev_stop;
  logic ev_dbl;
  wire active = dim_fn && !blocked_reg;
  wire p_due_long = p_t_reg >= long_ms;
  wire p_due_win = p_t_reg >= win_ms;

  always_comb begin
    state_next = state_reg;
    ev_short = 1'b0;
    ev_long = 1'b0;
    ev_stop = 1'b0;
    ev_dbl = 1'b0;
    unique case (state_reg)
      st_idle: begin
        if (press_ev) begin
          state_next = st_press;
        end
      end
      st_press: begin
        if (release_ev) begin
          if (dc_en) begin
            state_next = st_wait_dc;
          end else begin
            ev_short = 1'b1;
            state_next = st_idle;
          end
        end else if (p_due_long) begin
          ev_long = 1'b1;
          state_next = st_long;
        end
      end
      st_long: begin
        if (release_ev) begin
          ev_stop = 1'b1;
          state_next = st_idle;
        end
      end
      st_wait_dc: begin
        if (press_ev && !p_due_win) begin
          ev_dbl = 1'b1;
          state_next = st_dc_press;
        end else if (p_due_win) begin
          ev_short = 1'b1;
          state_next = st_idle;
        end
      end
      st_dc_press: begin
        if (release_ev) begin
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
    if (!active) begin
      state_next = st_idle;
      ev_short = 1'b0;
      ev_long = 1'b0;
      ev_stop = 1'b0;
      ev_dbl = 1'b0;
    end
  end

  wire ms_t p_t_next = (state_next != state_reg) ? 14'h0 :
    (tick && p_t_reg != 14'h3fff) ? p_t_reg + 14'h1 : p_t_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= st_idle;
      p_t_reg <= 14'h0;
    end else begin
      state_reg <= state_next;
      p_t_reg <= p_t_next;
    end
  end

  // ****************************************
  // Restoration
  // ****************************************
  logic rest_pend_reg;
  ms_t rest_t_reg;
  // Fires on a tick, leaving software time to set the action first
  wire rest_fire = rest_pend_reg && tick && rest_t_reg >= rest_ms;
  wire ms_t rest_t_next = (tick && rest_pend_reg && !rest_fire) ? rest_t_reg + 14'h1 : rest_t_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rest_pend_reg <= 1'b1;
      rest_t_reg <= 14'h0;
    end else begin
      rest_pend_reg <= rest_pend_reg && !rest_fire;
      rest_t_reg <= rest_t_next;
    end
  end

  // ****************************************
  // Command selection
  // ****************************************
  logic toggle_state_reg;
  logic dir_up_reg;
  wire dim_cmd_e toggle_cmd = toggle_state_reg ? cmd_off : cmd_on;
  dim_cmd_e short_cmd;
  dim_cmd_e long_cmd;
  dim_cmd_e cmd_next;

  always_comb begin
    unique case (mode)
      mode_up_on: begin
        short_cmd = cmd_on;
        long_cmd = cmd_up;
      end
      mode_up_toggle: begin
        short_cmd = toggle_cmd;
        long_cmd = cmd_up;
      end
      mode_down_off: begin
        short_cmd = cmd_off;
        long_cmd = cmd_down;
      end
      mode_down_toggle: begin
        short_cmd = toggle_cmd;
        long_cmd = cmd_down;
      end
      default: begin
        short_cmd = toggle_cmd;
        long_cmd = dir_up_reg ? cmd_up : cmd_down;
      end
    endcase
  end

  wire dim_cmd_e rest_cmd = (rest_act == 2'h1) ? cmd_on :
    (rest_act == 2'h2) ? cmd_off : cmd_none;
  wire dim_cmd_e set_cmd = (blk_set == 2'h2) ? cmd_on :
    (blk_set == 2'h3) ? cmd_off : cmd_none;
  wire dim_cmd_e clr_cmd = (blk_clr == 2'h1) ? cmd_on :
    (blk_clr == 2'h2) ? cmd_off : cmd_none;
  wire dim_cmd_e btn_cmd = ev_short ? short_cmd :
    ev_long ? long_cmd :
    ev_stop ? cmd_stop :
    ev_dbl ? cmd_double : cmd_none;

  always_comb begin
    cmd_next = btn_cmd;
    if (rest_fire && rest_cmd != cmd_none) begin
      cmd_next = rest_cmd;
    end else if (blk_set_ev && set_cmd != cmd_none) begin
      cmd_next = set_cmd;
    end else if (blk_clr_ev && clr_cmd != cmd_none) begin
      cmd_next = clr_cmd;
    end
  end

  wire toggle_next = (cmd_next == cmd_on) ? 1'b1 :
    (cmd_next == cmd_off) ? 1'b0 : toggle_state_reg;
  wire flip_dir = ev_long && mode == mode_one && cmd_next == long_cmd;
  wire dir_next = flip_dir ? !dir_up_reg : dir_up_reg;
  wire [2:0] step_next = (cmd_next == cmd_up || cmd_next == cmd_down) ?
    inc_sel : step_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      toggle_state_reg <= 1'b0;
      dir_up_reg <= 1'b1;
      cmd_out <= cmd_none;
      cmd_valid_out <= 1'b0;
      step_out <= 3'h0;
    end else begin
      toggle_state_reg <= toggle_next;
      dir_up_reg <= dir_next;
      cmd_out <= cmd_next;
      cmd_valid_out <= cmd_next != cmd_none;
      step_out <= step_next;
    end
  end

  // ****************************************
  // Status and read data
  // ****************************************
  assign status_word = {26'h0, rest_pend_reg, state_reg == st_long,
    dir_up_reg, blocked_reg, toggle_state_reg, level_reg};
  assign rd_data_next = !rd_en_in ? 32'h0 :
    sel_cfg ? {5'h0, cfg_reg} :
    sel_blk ? {31'h0, blk_obj_reg} :
    sel_sts ? status_word : 32'h0;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h0;
      blocked_out <= 1'b0;
      level_out <= 1'b0;
    end else begin
      rd_data_out <= rd_data_next;
      blocked_out <= blocked_reg;
      level_out <= level_reg;
    end
  end

endmodule // input_dimming_channel

// >>> testbench/input_dimming_channel_chk.sv
`timescale 1ns/1ps
module input_dimming_channel_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic contact_in,
  input wire logic [31:0] rd_data_out,
  input wire logic cmd_valid_out,
  input wire dim_pkg::dim_cmd_e cmd_out,
  input wire logic [2:0] step_out,
  input wire logic blocked_out,
  input wire logic level_out
);
  import dim_pkg::*;
  // ********
  // Checks
  // ********
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_dim;
    cmd_valid_out && (cmd_out == cmd_up || cmd_out == cmd_down);
  endsequence
  sequence s_stop;
    cmd_valid_out && cmd_out == cmd_stop;
  endsequence
  AST_CMD_PAIR: assert property (cmd_valid_out == (cmd_out != cmd_none))
    else $error("command valid and code disagree");
  AST_RD_ONE: assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
    else $error("read data outside its cycle");
  AST_RD_UNMAPPED: assert property (rd_en_in && addr_in == 8'h0c |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
  AST_DEB_RISE: assert property ($rose(level_out) |-> $past(contact_in, 2) && $past(contact_in, 8))
    else $error("level rose on unstable contact");
  AST_DEB_FALL: assert property ($fell(level_out) |-> !$past(contact_in, 2) && !$past(contact_in, 8))
    else $error("level fell on unstable contact");
  AST_LONG_HELD: assert property (s_dim |-> level_out && $past(level_out, 8))
    else $error("dim command without held press");
  AST_STOP_REL: assert property (s_stop |=> !level_out)
    else $error("stop while still pressed");
  AST_STEP_HOLD: assert property (!(cmd_valid_out && (cmd_out == cmd_up || cmd_out == cmd_down))
    |-> $stable(step_out))
    else $error("step changed without dim command");
  AST_DOUBLE_PRESS: assert property (cmd_valid_out && cmd_out == cmd_double |=> level_out)
    else $error("double click without press");
  AST_BLOCK_QUIET: assert property (blocked_out && $past(blocked_out)
    |-> !(cmd_valid_out && cmd_out inside {cmd_up, cmd_down, cmd_stop, cmd_double}))
    else $error("button command while blocked");
endmodule // input_dimming_channel_chk

// >>> testbench/dim_actuator_model.sv
`timescale 1ns/1ps
module dim_actuator_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire dim_pkg::dim_cmd_e cmd_in,
  input wire logic [2:0] step_in,
  output logic lamp_on_out,
  output logic dimming_out
);
  import dim_pkg::*;
  // ********
  // Lamp state
  // ********
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lamp_on_out <= 1'b0;
      dimming_out <= 1'b0;
    end else if (cmd_valid_in) begin
      if (cmd_in == cmd_on || cmd_in == cmd_up) lamp_on_out <= 1'b1;
      if (cmd_in == cmd_off) lamp_on_out <= 1'b0;
      if (cmd_in == cmd_up || cmd_in == cmd_down) dimming_out <= (step_in == 3'h0);
      if (cmd_in == cmd_stop) dimming_out <= 1'b0;
    end
  end
endmodule // dim_actuator_model

// >>> testbench/input_dimming_channel_test.sv
`timescale 1ns/1ps
`include "dim_defs.svh"
module input_dimming_channel_test;
  import dim_pkg::*;
  localparam int T = 4;
  localparam logic [31:0] BASE = {5'h00, `CFG_RESET};
  logic clk_in, rst_in, wr_en_in, rd_en_in, contact_in, cmd_valid_out, blocked_out, level_out, lamp_on, dimming;
  logic [7:0] addr_in;
  logic [31:0] wr_data_in, rd_data_out, rd_val;
  dim_cmd_e cmd_out;
  logic [2:0] step_out;
  int n_fail, n_tests, seed, tog, k, j, h;
  input_dimming_channel #(.TICK_CYCLES(T)) input_dimming_channel_inst (.clk_in, .rst_in, .addr_in, .wr_data_in,
    .wr_en_in, .rd_en_in, .contact_in, .rd_data_out, .cmd_valid_out, .cmd_out, .step_out, .blocked_out, .level_out);
  dim_actuator_model dim_actuator_model_inst (.clk_in, .rst_in, .cmd_valid_in(cmd_valid_out), .cmd_in(cmd_out),
    .step_in(step_out), .lamp_on_out(lamp_on), .dimming_out(dimming));
  // ********
  // Tasks
  // ********
  task automatic close_out();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    @(posedge clk_in);
    rd_val = rd_data_out;
  endtask
  task automatic set_contact(input logic v);
    @(posedge clk_in);
    contact_in <= v;
  endtask
  task automatic quiet(input int n);
    k = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (cmd_valid_out !== 1'b0) k++;
    end
    check(k == 0, "unexpected command");
  endtask
  task automatic expect_cmd(input dim_cmd_e e, input int bound);
    k = 0;
    while (cmd_valid_out !== 1'b1 && k < bound) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    if (cmd_valid_out !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t command never came", $time);
      close_out();
    end else begin
      check(cmd_out === e, "wrong command");
      if (e == cmd_on || e == cmd_off) tog = (e == cmd_on);
      @(posedge clk_in);
      #1;
    end
  endtask
  function automatic dim_cmd_e exp_short(input int mode, input int t);
    if (mode == 1) return cmd_on;
    if (mode == 3) return cmd_off;
    return (t != 0) ? cmd_off : cmd_on;
  endfunction
  task automatic short_push(input int mode);
    h = 100 + ($unsigned($random(seed)) % 120);
    set_contact(1'b1);
    quiet(h * T);
    set_contact(1'b0);
    expect_cmd(exp_short(mode, tog), 80 * T);
  endtask
  task automatic long_push(input dim_cmd_e e, input logic [2:0] inc);
    set_contact(1'b1);
    expect_cmd(e, 400 * T);
    check(step_out === inc, "step select");
    check(dimming === (inc == 3'h0), "actuator dimming state");
    set_contact(1'b0);
    expect_cmd(cmd_stop, 80 * T);
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    seed = 1597;
    n_fail = 0;
    n_tests = 0;
    tog = 0;
    rst_in = 1'b1;
    addr_in = 8'h00;
    wr_data_in = 32'h0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    contact_in = 1'b0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`REG_CFG);
    check(rd_val === BASE, "config reset value");
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c);
    check(rd_val === 32'h0, "unmapped read");
    set_contact(1'b1);
    quiet(20 * T);
    check(level_out === 1'b0, "glitch accepted");
    set_contact(1'b0);
    quiet(80 * T);
    for (j = 0; j < 3; j++) short_push(0);
    check(lamp_on === (tog != 0), "actuator lamp state");
    for (j = 0; j < 7; j++) begin
      wr(`REG_CFG, BASE | (j << `F_INC));
      long_push((j % 2 == 0) ? cmd_up : cmd_down, j[2:0]);
    end
    for (j = 1; j < 5; j++) begin
      wr(`REG_CFG, BASE | (j << `F_MODE));
      short_push(j);
      long_push((j < 3) ? cmd_up : cmd_down, 3'h0);
    end
    wr(`REG_CFG, BASE | (1 << `F_DC_EN));
    set_contact(1'b1);
    quiet(100 * T);
    set_contact(1'b0);
    quiet(80 * T);
    set_contact(1'b1);
    expect_cmd(cmd_double, 80 * T);
    set_contact(1'b0);
    quiet(400 * T);
    wr(`REG_CFG, BASE | (1 << `F_BLK_EN) | (2 << `F_BLK_SET) | (2 << `F_BLK_CLR));
    wr(`REG_BLOCK, 32'h1);
    expect_cmd(cmd_on, 8);
    check(blocked_out === 1'b1, "block not taken");
    set_contact(1'b1);
    quiet(400 * T);
    set_contact(1'b0);
    quiet(100 * T);
    wr(`REG_BLOCK, 32'h0);
    expect_cmd(cmd_off, 8);
    wr(`REG_CFG, BASE | (3 << `F_BLK_EN) | (3 << `F_BLK_SET) | (1 << `F_BLK_CLR));
    expect_cmd(cmd_off, 8);
    wr(`REG_BLOCK, 32'h1);
    expect_cmd(cmd_on, 8);
    wr(`REG_CFG, BASE | (3 << `F_BLK_EN));
    wr(`REG_BLOCK, 32'h0);
    quiet(20);
    check(blocked_out === 1'b0, "ignored block taken");
    short_push(0);
    wr(`REG_CFG, BASE);
    wr(`REG_BLOCK, 32'h1);
    quiet(20);
    check(blocked_out === 1'b0, "disabled block taken");
    wr(`REG_CFG, (BASE & ~32'h7) | 32'h5);
    set_contact(1'b1);
    quiet(900 * T);
    check(level_out === 1'b0, "long debounce accepted early");
    set_contact(1'b0);
    quiet(20 * T);
    for (j = 1; j < 3; j++) begin
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      wr(`REG_CFG, BASE | (j << `F_REST_ACT) | (1 << `F_REST_DLY));
      quiet(4900 * T);
      expect_cmd((j == 1) ? cmd_on : cmd_off, 200 * T);
    end
    close_out();
  end
endmodule // input_dimming_channel_test
bind input_dimming_channel input_dimming_channel_chk input_dimming_channel_chk_inst (.clk_in, .rst_in, .addr_in,
  .wr_data_in, .wr_en_in, .rd_en_in, .contact_in, .rd_data_out, .cmd_valid_out, .cmd_out, .step_out, .blocked_out,
  .level_out);
